// ==== dv/eif_far_side.sv ====
/*
 * eif_far_side: model of the pins and of the low clock tick.
 * Assumes the bench sets wanted pin levels by non-blocking assignment.
 */
`timescale 1ns/1ps
`default_nettype none

module eif_far_side #(
    parameter int TICK_DIV = 4
) (
    input  wire logic       clk,     // gear clock
    input  wire logic       rst,     // synchronous, active high
    input  wire logic [1:0] level,   // wanted pin levels
    output var  logic [1:0] pin,     // pins, moved just after an edge
    output var  logic       lf_tick  // one pulse per low clock period
);
    int cnt_q;

    // known levels from time zero so the block never sees an unknown pin
    initial begin
        pin = 2'h0;
        lf_tick = 1'b0;
        cnt_q = 0;
    end

    // registered pins and a free tick divider
    always @(posedge clk) begin
        pin <= level;
        cnt_q <= (rst || cnt_q == TICK_DIV - 1) ? 0 : cnt_q + 1;
        lf_tick <= !rst && cnt_q == TICK_DIV - 1;
    end
endmodule

`default_nettype wire

// ==== dv/eif_top_tb.sv ====
/*
 * eif_top_tb: register, edge, filter, gate and interrupt tests.
 * Assumes eif_far_side drives the pins and the low clock tick.
 */
`timescale 1ns/1ps
`default_nettype none

module eif_top_tb
    import eif_pkg::*;
;
    logic        clk, rst, psel, penable, pwrite, pready, pslverr, irq;
    logic        slow_mode, tick, err, lvl, hit;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0]  pins, ext_pin, irq_req;
    int          n_fail, cmp_count, cyc, n_req;

    eif_top DUT (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ext_pin(ext_pin),
        .slow_mode(slow_mode), .low_freq_tick(tick), .irq_req(irq_req), .irq(irq));

    eif_far_side FAR (.clk(clk), .rst(rst), .level(pins), .pin(ext_pin), .lf_tick(tick));

    // clock and hang guard
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            report_and_stop();
        end
    end

    // counts channel 2 request pulses; a pulse that stands too long counts twice
    always @(posedge clk) begin
        if (irq_req[0] === 1'b1) begin
            n_req <= n_req + 1;
        end
    end

    task automatic report_and_stop();
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask

    // one apb transfer, held until pready is seen high
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input string nm, input logic [15:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(nm, rd, exp);
    endtask

    // a short pulse must be filtered out, a long one must request
    task automatic filt(input int d);
        apb(1'b0, ADDR_STATUS, 32'h0);
        for (int k = 0; k < 2; k++) begin
            pins[0] <= 1'b1;
            wt(k ? 5 * d + 4 : 2 * d);
            pins[0] <= 1'b0;
            wt(5 * d + 4);
            rdchk("filter status", ADDR_STATUS, 32'(k));
        end
    endtask

    // main sequence
    initial begin
        rst = 1'b1;
        {psel, penable, pwrite, slow_mode} = 4'h0;
        paddr = 16'h0;
        pwdata = 32'h0;
        pins = 2'h0;
        {n_fail, cmp_count, cyc, n_req} = '0;
        wt(3);
        rst <= 1'b0;
        rdchk("ctrl2 reset", ADDR_CH2_CTRL, 32'h0);
        rdchk("mask reset", ADDR_MASK, 32'h0);
        apb(1'b1, ADDR_GATE, 32'h3);
        apb(1'b1, ADDR_CH2_CTRL, 32'hFFFFFFF6);
        rdchk("ctrl2 fields", ADDR_CH2_CTRL, 32'h06);
        lvl = 1'b0;
        for (int e = 0; e < 3; e++) begin
            apb(1'b1, ADDR_CH2_CTRL, 32'(e << 2));
            wt(10);
            apb(1'b0, ADDR_STATUS, 32'h0);
            for (int p = 1; p >= 0; p--) begin
                pins[0] <= p[0];
                wt(10);
                hit = (e == 2) || (e == (p ? 0 : 1));
                if (hit) lvl = p[0];
                rdchk("edge status", ADDR_STATUS, {31'h0, hit});
                rdchk("ctrl2 level", ADDR_CH2_CTRL, {27'h0, lvl, e[1:0], 2'h0});
            end
        end
        // reserved edge code must never request, on either edge
        apb(1'b1, ADDR_CH2_CTRL, 32'hC);
        apb(1'b0, ADDR_STATUS, 32'h0);
        pins[0] <= 1'b1;
        wt(10);
        rdchk("reserved rise", ADDR_STATUS, 32'h0);
        rdchk("reserved ctrl", ADDR_CH2_CTRL, 32'h0C);
        pins[0] <= 1'b0;
        wt(10);
        rdchk("reserved fall", ADDR_STATUS, 32'h0);
        chk("req pulses", 32'(n_req), 32'h4);
        apb(1'b1, ADDR_CH2_CTRL, 32'h8);
        // interrupt raised, cleared by read, then masked
        apb(1'b1, ADDR_MASK, 32'h1);
        pins[0] <= 1'b1;
        wt(10);
        chk("irq set", {31'h0, irq}, 32'h1);
        rdchk("status", ADDR_STATUS, 32'h1);
        wt(2);
        chk("irq clear", {31'h0, irq}, 32'h0);
        apb(1'b1, ADDR_MASK, 32'h0);
        pins[0] <= 1'b0;
        wt(10);
        chk("irq masked", {31'h0, irq}, 32'h0);
        rdchk("status masked", ADDR_STATUS, 32'h1);
        chk("req pulses both", 32'(n_req), 32'h6);
        for (int r = 0; r < 4; r++) begin
            apb(1'b1, ADDR_CH2_CTRL, 32'(r));
            wt(8);
            filt(r == 0 ? 1 : 2 << r);
        end
        apb(1'b1, ADDR_CH2_CTRL, 32'h0);
        slow_mode <= 1'b1;
        wt(48);
        filt(16);
        slow_mode <= 1'b0;
        wt(10);
        apb(1'b1, ADDR_CH3_CTRL, 32'h0);
        wt(8);
        apb(1'b0, ADDR_STATUS, 32'h0);
        pins[1] <= 1'b1;
        wt(10);
        rdchk("ch3 status", ADDR_STATUS, 32'h2);
        rdchk("ch3 level", ADDR_CH3_CTRL, 32'h10);
        // gate off clears and stops the channels
        apb(1'b1, ADDR_GATE, 32'h0);
        apb(1'b1, ADDR_CH2_CTRL, 32'h8);
        rdchk("ctrl2 gated", ADDR_CH2_CTRL, 32'h0);
        rdchk("ctrl3 gated", ADDR_CH3_CTRL, 32'h0);
        pins <= 2'h1;
        wt(10);
        rdchk("gated status", ADDR_STATUS, 32'h0);
        apb(1'b0, 16'h3F00, 32'h0);
        chk("unmapped err", {31'h0, err}, 32'h1);
        chk("unmapped data", rd, 32'h0);
        report_and_stop();
    end
endmodule

`default_nettype wire

// ==== rtl/eif_pkg.sv ====
/*
 * eif_pkg: constants and types for the two-channel external interrupt
 * edge detector with noise filter.
 * Assumes an APB slave with 32-bit data and 16-bit byte addresses.
 */
package eif_pkg;

    // register indices; the byte address is four times the index
    localparam logic [11:0] IDX_CH2_CTRL = 12'hFD9;
    localparam logic [11:0] IDX_CH3_CTRL = 12'hFDA;
    localparam logic [11:0] IDX_GATE     = 12'hFE0;
    localparam logic [11:0] IDX_STATUS   = 12'hFE1;
    localparam logic [11:0] IDX_MASK     = 12'hFE2;

    localparam logic [15:0] ADDR_CH2_CTRL = {2'h0, IDX_CH2_CTRL, 2'h0};
    localparam logic [15:0] ADDR_CH3_CTRL = {2'h0, IDX_CH3_CTRL, 2'h0};
    localparam logic [15:0] ADDR_GATE     = {2'h0, IDX_GATE, 2'h0};
    localparam logic [15:0] ADDR_STATUS   = {2'h0, IDX_STATUS, 2'h0};
    localparam logic [15:0] ADDR_MASK     = {2'h0, IDX_MASK, 2'h0};

    // control register field positions
    localparam int RATE_LSB  = 0;
    localparam int EDGE_LSB  = 2;
    localparam int LEVEL_BIT = 4;

    // edge-select codes
    localparam logic [1:0] EDGE_RISE = 2'h0;
    localparam logic [1:0] EDGE_FALL = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h2;

    // fast-mode divider masks: divide by 1, 4, 8, 16
    localparam logic [3:0] DIV_MASK_1  = 4'h0;
    localparam logic [3:0] DIV_MASK_4  = 4'h3;
    localparam logic [3:0] DIV_MASK_8  = 4'h7;
    localparam logic [3:0] DIV_MASK_16 = 4'hF;

    // slow modes sample at the low-frequency clock divided by 4
    localparam logic [1:0] LF_DIV_LAST = 2'h3;

    // consecutive equal samples the filter needs before its output moves
    localparam int FILT_SAMPLES = 3;

    // reset values
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam logic [1:0] MASK_RESET = 2'h0;

    typedef struct packed {
        logic [1:0] edge_sel;
        logic [1:0] rate;
    } eif_ctrl_type;

    localparam eif_ctrl_type CTRL_ZERO = '{edge_sel: CTRL_RESET, rate: CTRL_RESET};

endpackage

// ==== rtl/eif_top.sv ====
/*
 * eif_top: two external interrupt channels, each with a noise filter whose
 * sampling rate software selects outside slow mode, an edge detector, a last-level flag,
 * per-channel power gate, sticky status, mask and one interrupt line.
 * Assumes pins and low_freq_tick are synchronous to clk and that the
 * gear clock is clk itself.
 */
`timescale 1ns/1ps
`default_nettype none

module eif_top
    import eif_pkg::*;
#(
    parameter int NCH = 2
) (
    input  wire logic             clk,           // 20 MHz gear clock
    input  wire logic             rst,           // synchronous, active high
    input  wire logic             psel,          // apb select
    input  wire logic             penable,       // apb access phase
    input  wire logic             pwrite,        // apb direction
    input  wire logic [15:0]      paddr,         // apb byte address
    input  wire logic [31:0]      pwdata,        // apb write data
    output logic      [31:0]      prdata,        // apb read data
    output logic                  pready,        // apb ready
    output logic                  pslverr,       // unmapped address
    input  wire logic [NCH-1:0]   ext_pin,       // channel pins, index 0 is ch2
    input  wire logic             slow_mode,     // 1 in slow run or sleep modes
    input  wire logic             low_freq_tick, // one pulse per low clock period
    output logic      [NCH-1:0]   irq_req,       // request pulses to the latch
    output logic                  irq            // level, unmasked status set
);

    logic [31:0]        rdata_q, rdata_d;
    logic               err_q, err_d;
    logic [NCH-1:0]     gate_q, gate_d;
    logic [NCH-1:0]     status_q, status_d;
    logic [NCH-1:0]     mask_q, mask_d;
    eif_ctrl_type       ctrl_q [NCH];
    logic [NCH-1:0]     lvl_q;
    logic [NCH-1:0]     filt_q;
    logic               setup, acc_wr, acc_rd;
    logic [NCH-1:0]     ctrl_wr;

    assign setup  = psel & ~penable;
    assign acc_wr = psel & penable & pwrite;
    assign acc_rd = psel & penable & ~pwrite;
    assign ctrl_wr[0] = acc_wr & (paddr == ADDR_CH2_CTRL);
    assign ctrl_wr[1] = acc_wr & (paddr == ADDR_CH3_CTRL);

    // apb: read data captured in setup, every access completes in one cycle
    assign pready  = 1'b1;
    assign prdata  = rdata_q;
    assign pslverr = psel & penable & err_q;

    // bus decode, read capture and software-owned registers
    always_comb begin
        rdata_d  = rdata_q;
        err_d    = err_q;
        gate_d   = gate_q;
        mask_d   = mask_q;
        status_d = status_q;
        if (setup) begin
            err_d   = 1'b0;
            rdata_d = 32'h0;
            unique case (paddr)
                ADDR_CH2_CTRL: rdata_d[7:0] = {3'h0, lvl_q[0], ctrl_q[0]};
                ADDR_CH3_CTRL: rdata_d[7:0] = {3'h0, lvl_q[1], ctrl_q[1]};
                ADDR_GATE:     rdata_d[NCH-1:0] = gate_q;
                ADDR_STATUS:   rdata_d[NCH-1:0] = status_q;
                ADDR_MASK:     rdata_d[NCH-1:0] = mask_q;
                default:       err_d = 1'b1;
            endcase
        end
        if (acc_wr && paddr == ADDR_GATE) begin
            gate_d = pwdata[NCH-1:0];
        end
        if (acc_wr && paddr == ADDR_MASK) begin
            mask_d = pwdata[NCH-1:0];
        end
        // read clears only the bits that were returned; a new set still wins
        if (acc_rd && paddr == ADDR_STATUS) begin
            status_d = status_d & ~rdata_q[NCH-1:0];
        end
        status_d = status_d | irq_req;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_q  <= 32'h0;
            err_q    <= 1'b0;
            gate_q   <= '0;
            mask_q   <= MASK_RESET;
            status_q <= '0;
        end else begin
            rdata_q  <= rdata_d;
            err_q    <= err_d;
            gate_q   <= gate_d;
            mask_q   <= mask_d;
            status_q <= status_d;
        end
    end

    assign irq = |(status_q & mask_q);

    // one filter, edge detector and control register per channel
    for (genvar c = 0; c < NCH; c++) begin : g_ch
        eif_ctrl_type              ctrl_d;
        logic [3:0]                div_q, div_d;
        logic [1:0]                lf_q, lf_d;
        logic [FILT_SAMPLES-1:0]   sh_q, sh_d;
        logic                      filt_d, lvl_d;
        logic [3:0]                dmask;
        logic                      tick, rise, fall;

        // sampling tick from the selected rate, or from the low clock divided by 4 in slow mode
        always_comb begin
            unique case (ctrl_q[c].rate)
                2'h0: dmask = DIV_MASK_1;
                2'h1: dmask = DIV_MASK_4;
                2'h2: dmask = DIV_MASK_8;
                2'h3: dmask = DIV_MASK_16;
            endcase
            if (slow_mode) begin
                tick = low_freq_tick & (lf_q == LF_DIV_LAST);
            end else begin
                tick = (div_q & dmask) == 4'h0;
            end
        end

        // filter output moves only after equal consecutive samples
        always_comb begin
            div_d  = div_q + 4'h1;
            lf_d   = low_freq_tick ? lf_q + 2'h1 : lf_q;
            sh_d   = tick ? {sh_q[FILT_SAMPLES-2:0], ext_pin[c]} : sh_q;
            filt_d = filt_q[c];
            if (&sh_d) begin
                filt_d = 1'b1;
            end else if (~|sh_d) begin
                filt_d = 1'b0;
            end
        end

        // edge select on the filtered level; reserved code raises nothing
        assign rise = filt_d & ~filt_q[c];
        assign fall = ~filt_d & filt_q[c];
        always_comb begin
            unique case (ctrl_q[c].edge_sel)
                EDGE_RISE: irq_req[c] = gate_q[c] & rise;
                EDGE_FALL: irq_req[c] = gate_q[c] & fall;
                EDGE_BOTH: irq_req[c] = gate_q[c] & (rise | fall);
                default:   irq_req[c] = 1'b0;
            endcase
        end

        // control fields take only bits 3:0; level follows each request
        always_comb begin
            ctrl_d = ctrl_q[c];
            lvl_d  = lvl_q[c];
            if (ctrl_wr[c]) begin
                ctrl_d = pwdata[EDGE_LSB+1:RATE_LSB];
            end
            if (irq_req[c]) begin
                lvl_d = filt_d;
            end
        end

        always_ff @(posedge clk) begin
            if (rst || !gate_q[c]) begin
                ctrl_q[c] <= CTRL_ZERO;
                lvl_q[c]  <= 1'b0;
                filt_q[c] <= 1'b0;
                div_q     <= 4'h0;
                lf_q      <= 2'h0;
                sh_q      <= '0;
            end else begin
                ctrl_q[c] <= ctrl_d;
                lvl_q[c]  <= lvl_d;
                filt_q[c] <= filt_d;
                div_q     <= div_d;
                lf_q      <= lf_d;
                sh_q      <= sh_d;
            end
        end

        level_follow_a: assert property (@(posedge clk) disable iff (rst)
            irq_req[c] |=> lvl_q[c] == filt_q[c])
            else $error("level flag not updated on request");
        rise_only_a: assert property (@(posedge clk) disable iff (rst)
            irq_req[c] && ctrl_q[c].edge_sel == EDGE_RISE |=> filt_q[c] && !$past(filt_q[c]))
            else $error("rising select raised request without rising edge");
        reserved_edge_a: assert property (@(posedge clk) disable iff (rst)
            ctrl_q[c].edge_sel == 2'h3 |-> !irq_req[c])
            else $error("reserved edge code raised request");
        // a rate or mode change excuses a cycle; the divider keeps its phase across it
        rate_div8_a: assert property (@(posedge clk) disable iff (rst || !gate_q[c])
            !slow_mode && ctrl_q[c].rate == 2'h2 && tick |=>
            (!tick || slow_mode || ctrl_q[c].rate != 2'h2)[*7]
            ##1 (tick || slow_mode || ctrl_q[c].rate != 2'h2))
            else $error("divide-by-8 sampling spacing wrong");
        gate_clear_a: assert property (@(posedge clk) disable iff (rst)
            !gate_q[c] |=> ctrl_q[c] == CTRL_ZERO && !lvl_q[c] && !irq_req[c])
            else $error("gated channel kept state");
        level_ro_a: assert property (@(posedge clk) disable iff (rst)
            ctrl_wr[c] && !irq_req[c] && gate_q[c] |=> lvl_q[c] == $past(lvl_q[c]))
            else $error("write changed level flag");
        level_reset_a: assert property (@(posedge clk)
            rst |=> !lvl_q[c] && ctrl_q[c] == CTRL_ZERO)
            else $error("level flag not zero after reset");
        req_status_a: assert property (@(posedge clk) disable iff (rst)
            irq_req[c] |=> status_q[c])
            else $error("request did not set status");
        rise_req_c: cover property (@(posedge clk)
            irq_req[c] && ctrl_q[c].edge_sel == EDGE_RISE);
        fall_req_c: cover property (@(posedge clk)
            irq_req[c] && ctrl_q[c].edge_sel == EDGE_FALL);
        slow_req_c: cover property (@(posedge clk) irq_req[c] && slow_mode);
    end

    reserved_read_a: assert property (@(posedge clk) disable iff (rst)
        setup && (paddr == ADDR_CH2_CTRL || paddr == ADDR_CH3_CTRL) |=> rdata_q[31:5] == 27'h0)
        else $error("reserved control bits read nonzero");
    irq_cover_c: cover property (@(posedge clk) irq);

endmodule

`default_nettype wire
